// ### logic/i2cs_pkg.sv
// package: register map, fields and codes of the i2c client block
package i2cs_pkg;
	// register word indices (printed offsets are indices, times four)
	localparam logic [7:0] IDX_CTRL = 8'h09;
	localparam logic [7:0] IDX_CMD = 8'h0A;
	localparam logic [7:0] IDX_STATUS = 8'h0B;
	localparam logic [7:0] IDX_ADDR = 8'h0C;
	localparam logic [7:0] IDX_DATA = 8'h0D;
	localparam logic [7:0] IDX_GIE = 8'h10;
	localparam logic [11:0] OFS_CTRL = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [11:0] OFS_CMD = {2'h0, IDX_CMD, 2'h0};
	localparam logic [11:0] OFS_STATUS = {2'h0, IDX_STATUS, 2'h0};
	localparam logic [11:0] OFS_ADDR = {2'h0, IDX_ADDR, 2'h0};
	localparam logic [11:0] OFS_DATA = {2'h0, IDX_DATA, 2'h0};
	localparam logic [11:0] OFS_GIE = {2'h0, IDX_GIE, 2'h0};
	// control fields
	localparam int B_DATA_INTERRUPT_ENABLE = 7;
	localparam int B_ADDRESS_STOP_INTERRUPT_ENABLE = 6;
	localparam int B_PSTOP = 5;
	localparam int B_PROM = 2;
	localparam int B_SMART = 1;
	localparam int B_EN = 0;
	localparam logic [7:0] CTRL_MASK = 8'hE7;
	// command register fields
	localparam int B_ACKNOWLEDGE_ACTION = 2;
	localparam logic [1:0] CMD_NO_ACTION_CODE = 2'h0;
	localparam logic [1:0] CMD_RSVD = 2'h1;
	localparam logic [1:0] CMD_COMPLETE_TRANSACTION_CODE = 2'h2;
	localparam logic [1:0] CMD_RESPONSE = 2'h3;
	// status fields
	localparam int B_DIF = 7;
	localparam int B_ADDRESS_OR_STOP_FLAG = 6;
	localparam int B_HOLD = 5;
	localparam int B_RECEIVED_ACKNOWLEDGE = 4;
	localparam int B_COLLISION_FLAG = 3;
	localparam int B_BERR = 2;
	localparam int B_DIR = 1;
	localparam int B_AP = 0;
	localparam logic [6:0] GENCALL = 7'h00;
	localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// ### logic/i2cs_client.sv
// file: i2c client with apb registers, acknowledge control and status flags
// Notes on behaviour
// - stop sets address flag when enabled
// - promiscuous bit accepts any address
// - smart mode: data access resumes transfer
// - enable bit gates all client activity but the collision clear on start
// - ack action: 0 ack, 1 nack
// - data write triggers acknowledge action only in receive direction
// - command strobe reads zero; 0,1 idle
// - code 2: ack action, wait start
// - code 3 after address: ack, data
// - code 3 host write: ack, receive
// - code 3 after data read: send byte
// - ack bit updated before command acts
// - data flag set on byte completion
// - data access or command clears data and address/stop flags
// - address match or stop sets flag
// - address or data byte event holds scl low, resume releases
// - received ack bit mirrors host ack
// - collision on lost high bit or nack
// - collision cleared by one or start
// - bus error on bad start/stop
// - data irq needs flag, enable, global
// - cause bit: 0 stop, 1 address
// - direction holds last address r/w bit
// - address bits 7:1, bit 0 general call
`timescale 1ns/100ps
`default_nettype none
module i2cs_client (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic data_irq,
	output logic addr_stop_irq
);
	typedef enum {ST_IDLE, ST_ADDR, ST_AHOLD, ST_RX, ST_TX, ST_ACKOUT,
		ST_ACKIN, ST_DHOLD, ST_WAITS} i2cs_state_t;
	i2cs_state_t st;
	// ==================================================
	// pin synchronisers and edges
	logic [1:0] scl_s, sda_s;
	logic scl_q, sda_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s <= {scl_s[0], scl_in};
			sda_s <= {sda_s[0], sda_in};
			scl_q <= scl_s[1];
			sda_q <= sda_s[1];
		end
	end
	wire logic scl_rise = scl_s[1] & ~scl_q;
	wire logic scl_fall = ~scl_s[1] & scl_q;
	// needs pclk at least four times scl to see sda move under high scl
	wire logic start_c = scl_s[1] & scl_q & sda_q & ~sda_s[1];
	wire logic stop_c = scl_s[1] & scl_q & ~sda_q & sda_s[1];
	// ==================================================
	// apb decode
	wire logic acc = psel & penable;
	wire logic wr = acc & pwrite;
	wire logic rd = acc & ~pwrite;
	wire logic mapped = paddr == i2cs_pkg::OFS_CTRL ||
		paddr == i2cs_pkg::OFS_CMD || paddr == i2cs_pkg::OFS_STATUS ||
		paddr == i2cs_pkg::OFS_ADDR || paddr == i2cs_pkg::OFS_DATA ||
		paddr == i2cs_pkg::OFS_GIE;
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;
	wire logic wr_ctrl = wr && paddr == i2cs_pkg::OFS_CTRL;
	wire logic wr_cmd = wr && paddr == i2cs_pkg::OFS_CMD;
	wire logic wr_stat = wr && paddr == i2cs_pkg::OFS_STATUS;
	wire logic wr_addr = wr && paddr == i2cs_pkg::OFS_ADDR;
	wire logic wr_gie = wr && paddr == i2cs_pkg::OFS_GIE;
	wire logic wr_data = wr && paddr == i2cs_pkg::OFS_DATA;
	wire logic rd_data = rd && paddr == i2cs_pkg::OFS_DATA;
	// ==================================================
	// software registers
	logic [7:0] ctrl, own_addr, data_reg;
	logic ack_act, gie;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= i2cs_pkg::RESET_BYTE;
			own_addr <= i2cs_pkg::RESET_BYTE;
			gie <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl <= pwdata[7:0] & i2cs_pkg::CTRL_MASK;
			if (wr_addr)
				own_addr <= pwdata[7:0];
			if (wr_gie)
				gie <= pwdata[0];
		end
	end
	// ack bit is a register; the command sees the written value directly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ack_act <= 1'b0;
		else if (wr_cmd)
			ack_act <= pwdata[i2cs_pkg::B_ACKNOWLEDGE_ACTION];
	end
	wire logic ack_now = wr_cmd ? pwdata[i2cs_pkg::B_ACKNOWLEDGE_ACTION] : ack_act;
	wire logic en = ctrl[i2cs_pkg::B_EN];
	wire logic smart = ctrl[i2cs_pkg::B_SMART];
	wire logic [1:0] cmd = pwdata[1:0];
	// ==================================================
	// flags
	logic data_flag, address_or_stop_flag, received_acknowledge, collision_flag, berr, dir, ap;
	wire logic hold = (st == ST_AHOLD) || (st == ST_DHOLD);
	wire logic flag_clr = wr_data || rd_data || wr_cmd;
	// resume: command 2/3, or smart-mode data access
	wire logic go_cmd = wr_cmd && (cmd == i2cs_pkg::CMD_COMPLETE_TRANSACTION_CODE ||
		cmd == i2cs_pkg::CMD_RESPONSE);
	wire logic go_smart = smart && (rd_data || wr_data);
	wire logic resume = hold && (go_cmd || go_smart);
	// response code 2 ends the transaction after the ack
	wire logic finish = wr_cmd && cmd == i2cs_pkg::CMD_COMPLETE_TRANSACTION_CODE;
	logic [7:0] shreg;
	logic [3:0] bitn;
	// a data write lands in data_reg at the same edge, so send pwdata itself
	wire logic [7:0] tx_byte = wr_data ? pwdata[7:0] : data_reg;
	logic ack_drive, nack_sent, fin_pend, addr_ok, ev_addr, ev_data, ev_stop;
	logic ev_collision_flag;
	wire logic [6:0] rx_addr = shreg[7:1];
	always_comb begin
		addr_ok = ctrl[i2cs_pkg::B_PROM];
		if (rx_addr == own_addr[7:1])
			addr_ok = 1'b1;
		if (own_addr[0] && rx_addr == i2cs_pkg::GENCALL)
			addr_ok = 1'b1;
	end
	// ==================================================
	// protocol engine
	logic busy;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= ST_IDLE;
			shreg <= i2cs_pkg::RESET_BYTE;
			bitn <= 4'h0;
			ack_drive <= 1'b0;
			nack_sent <= 1'b0;
			fin_pend <= 1'b0;
			ev_addr <= 1'b0;
			ev_data <= 1'b0;
			ev_stop <= 1'b0;
			ev_collision_flag <= 1'b0;
			dir <= 1'b0;
			received_acknowledge <= 1'b0;
			busy <= 1'b0;
			data_reg <= i2cs_pkg::RESET_BYTE;
		end else begin
			ev_addr <= 1'b0;
			ev_data <= 1'b0;
			ev_stop <= 1'b0;
			ev_collision_flag <= 1'b0;
			if (wr_data)
				data_reg <= pwdata[7:0];
			if (!en) begin
				st <= ST_IDLE;
				ack_drive <= 1'b0;
				busy <= 1'b0;
			end else if (start_c) begin
				st <= ST_ADDR;
				bitn <= 4'h0;
				ack_drive <= 1'b0;
				busy <= 1'b1;
			end else if (stop_c) begin
				st <= ST_IDLE;
				ack_drive <= 1'b0;
				ev_stop <= busy;
				busy <= 1'b0;
			end else begin
				case (st)
				ST_IDLE, ST_WAITS: begin
				end
				ST_ADDR, ST_RX: if (scl_rise) begin
					shreg <= {shreg[6:0], sda_s[1]};
					bitn <= bitn + 4'h1;
				end else if (scl_fall && bitn == 4'h8) begin
					bitn <= 4'h0;
					if (st == ST_ADDR) begin
						if (addr_ok) begin
							dir <= shreg[0];
							ev_addr <= 1'b1;
							st <= ST_AHOLD;
						end else
							st <= ST_WAITS;
					end else begin
						data_reg <= shreg;
						ev_data <= 1'b1;
						st <= ST_DHOLD;
					end
				end
				ST_AHOLD, ST_DHOLD: if (resume) begin
					fin_pend <= finish;
					if (finish && dir && st == ST_DHOLD) begin
						// host read is over: nothing to ack, wait for start
						st <= ST_WAITS;
					end else if (dir && (st == ST_DHOLD || wr_data)) begin
						// read direction after data, or a data write at address hold: send byte first
						shreg <= tx_byte;
						st <= ST_TX;
						ack_drive <= ~tx_byte[7];
					end else if (dir && st == ST_AHOLD && !go_smart) begin
						// ack the address, then data irq to load a byte
						ack_drive <= ~ack_now;
						nack_sent <= ack_now;
						st <= ST_ACKOUT;
					end else begin
						// rx side, and smart data reads at a read address: commands and smart data accesses apply the ack
						ack_drive <= ~ack_now;
						nack_sent <= ack_now;
						st <= ST_ACKOUT;
					end
				end
				ST_ACKOUT: if (scl_rise) begin
					if (nack_sent && !sda_s[1] && st == ST_ACKOUT)
						ev_collision_flag <= 1'b1;
				end else if (scl_fall) begin
					ack_drive <= 1'b0;
					if (fin_pend || nack_sent)
						st <= ST_WAITS;
					else if (dir) begin
						ev_data <= 1'b1;
						st <= ST_DHOLD;
					end else
						st <= ST_RX;
				end
				ST_TX: if (scl_rise) begin
					if (ack_drive == 1'b0 && !sda_s[1]) begin
						ev_collision_flag <= 1'b1;
						ev_data <= 1'b1;
						st <= ST_WAITS;
						ack_drive <= 1'b0;
					end
					bitn <= bitn + 4'h1;
				end else if (scl_fall) begin
					shreg <= {shreg[6:0], 1'b0};
					if (bitn == 4'h8) begin
						ack_drive <= 1'b0;
						bitn <= 4'h0;
						st <= ST_ACKIN;
					end else
						ack_drive <= ~shreg[6];
				end
				ST_ACKIN: if (scl_rise) begin
					received_acknowledge <= sda_s[1];
				end else if (scl_fall) begin
					ev_data <= 1'b1;
					st <= ST_DHOLD;
				end
				default: st <= ST_IDLE;
				endcase
			end
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe = ack_drive & en;
	assign scl_out = 1'b0;
	assign scl_oe = hold & en;
	// ==================================================
	// status flags; set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_flag <= 1'b0;
			address_or_stop_flag <= 1'b0;
			ap <= 1'b0;
			collision_flag <= 1'b0;
			berr <= 1'b0;
		end else begin
			if (ev_data)
				data_flag <= 1'b1;
			else if (flag_clr || (wr_stat && pwdata[i2cs_pkg::B_DIF]))
				data_flag <= 1'b0;
			if (ev_addr || (ev_stop && ctrl[i2cs_pkg::B_PSTOP])) begin
				address_or_stop_flag <= 1'b1;
				ap <= ev_addr;
			end else if (flag_clr || (wr_stat && pwdata[i2cs_pkg::B_ADDRESS_OR_STOP_FLAG]))
				address_or_stop_flag <= 1'b0;
			if (ev_collision_flag)
				collision_flag <= 1'b1;
			else if ((wr_stat && pwdata[i2cs_pkg::B_COLLISION_FLAG]) || start_c)
				collision_flag <= 1'b0;
			// start inside address byte or stop right after start
			if (en && ((start_c && st == ST_ADDR && bitn != 4'h0) ||
				(stop_c && st == ST_ADDR && bitn <= 4'h1 && busy)))
				berr <= 1'b1;
			else if (wr_stat && pwdata[i2cs_pkg::B_BERR])
				berr <= 1'b0;
		end
	end
	assign data_irq = data_flag & ctrl[i2cs_pkg::B_DATA_INTERRUPT_ENABLE] & gie;
	assign addr_stop_irq = address_or_stop_flag & ctrl[i2cs_pkg::B_ADDRESS_STOP_INTERRUPT_ENABLE] & gie;
	// ==================================================
	// read mux
	always_comb begin
		prdata = 32'h00000000;
		if (rd) begin
			case (paddr)
			i2cs_pkg::OFS_CTRL: prdata[7:0] = ctrl;
			i2cs_pkg::OFS_CMD: prdata[i2cs_pkg::B_ACKNOWLEDGE_ACTION] = ack_act;
			i2cs_pkg::OFS_STATUS: prdata[7:0] = {data_flag, address_or_stop_flag, hold, received_acknowledge,
				collision_flag, berr, dir, ap};
			i2cs_pkg::OFS_ADDR: prdata[7:0] = own_addr;
			i2cs_pkg::OFS_DATA: prdata[7:0] = data_reg;
			i2cs_pkg::OFS_GIE: prdata[0] = gie;
			default: prdata = 32'h00000000;
			endcase
		end
	end
	// ==================================================
	// checks
	a_hold_scl: assert property (@(posedge pclk) disable iff (!presetn)
		scl_oe |-> hold) else $error("scl held outside hold state");
	a_dis_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!en |-> !scl_oe && !sda_oe) else $error("lines driven while off");
	a_data_set: assert property (@(posedge pclk) disable iff (!presetn)
		ev_data |=> data_flag) else $error("data flag not set");
	a_flag_clr: assert property (@(posedge pclk) disable iff (!presetn)
		rd_data && !ev_data |=> !data_flag) else $error("data flag not cleared");
	a_addr_cause: assert property (@(posedge pclk) disable iff (!presetn)
		ev_addr |=> address_or_stop_flag && ap) else $error("address cause wrong");
	a_collision_flag_start: assert property (@(posedge pclk) disable iff (!presetn)
		start_c && !ev_collision_flag |=> !collision_flag) else $error("collision kept");
	a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
		data_irq |-> data_flag && gie) else $error("irq without cause");
	a_cmd_zero: assert property (@(posedge pclk) disable iff (!presetn)
		rd && paddr == i2cs_pkg::OFS_CMD |-> prdata[1:0] == 2'h0)
		else $error("command reads nonzero");
	// ==================================================
	// further checks on flags, lines and the engine
	a_cmd_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr_cmd && !ev_data |=> !data_flag) else $error("command left data flag");
	a_hold_release: assert property (@(posedge pclk) disable iff (!presetn)
		hold && resume && en |=> !scl_oe) else $error("scl not released");
	a_nack_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		st == ST_ACKOUT && nack_sent |-> !sda_oe) else $error("nack drove sda");
	a_prom_any: assert property (@(posedge pclk) disable iff (!presetn)
		en && !start_c && !stop_c && st == ST_ADDR && scl_fall &&
		bitn == 4'h8 && ctrl[i2cs_pkg::B_PROM] |=> st == ST_AHOLD)
		else $error("promiscuous address refused");
	a_stop_cause: assert property (@(posedge pclk) disable iff (!presetn)
		ev_stop && ctrl[i2cs_pkg::B_PSTOP] |=> address_or_stop_flag && !ap)
		else $error("stop flag or cause wrong");
	a_berr_set: assert property (@(posedge pclk) disable iff (!presetn)
		en && stop_c && st == ST_ADDR && busy && bitn <= 4'h1 |=> berr)
		else $error("bus error missed");
	a_idle_sda: assert property (@(posedge pclk) disable iff (!presetn)
		st == ST_IDLE |-> !sda_oe) else $error("sda driven while idle");
	a_addr_irq: assert property (@(posedge pclk) disable iff (!presetn)
		addr_stop_irq |-> address_or_stop_flag && gie) else $error("address irq without cause");
endmodule
`default_nettype wire

// ### test/i2cs_host.sv
// i2c host model driving the open-drain bus lines
`timescale 1ns/100ps
`default_nettype none
module i2cs_host (
	input wire logic pclk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_pull,
	output logic sda_pull
);
	// ====
	// bus timing
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// half of the 800 ns scl period
	task automatic half();
		repeat (4) @(posedge pclk);
	endtask
	// released scl may be held low by the client
	task automatic rise();
		scl_pull <= 1'b0;
		for (int i = 0; i < 4000 && scl !== 1'b1; i++) @(posedge pclk);
		half();
	endtask
	// ====
	// conditions and bits
	task automatic start();
		sda_pull <= 1'b1;
		half();
		scl_pull <= 1'b1;
		half();
	endtask
	task automatic bit_io(input logic b, output logic s);
		sda_pull <= !b;
		half();
		rise();
		s = sda;
		scl_pull <= 1'b1;
	endtask
	// msb first, then the ack slot with sda released
	task automatic byte_io(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, ack);
	endtask
	// read a byte from the client, then give ack (0) or nack (1)
	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(nack, s);
	endtask
	task automatic stop();
		sda_pull <= 1'b1;
		half();
		rise();
		sda_pull <= 1'b0;
		half();
	endtask
endmodule
`default_nettype wire

// ### test/tb.sv
// testbench: apb register and i2c bus scenarios for the client
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic scl_oe, sda_oe, scl_out, sda_out, data_irq, addr_stop_irq;
	logic hs, hd, ack, ack2, mon, bad;
	logic [7:0] rb;
	wire scl_w, sda_w;
	int errors, n_compared;
	// pull-ups: a released line reads high
	assign scl_w = !(hs || scl_oe);
	assign sda_w = !(hd || sda_oe);
	i2cs_client dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata),
		.scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .data_irq(data_irq),
		.addr_stop_irq(addr_stop_irq));
	i2cs_host host_u (.pclk(pclk), .scl(scl_w), .sda(sda_w),
		.scl_pull(hs), .sda_pull(hd));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (!presetn)
			bad <= 1'b0;
		else if (mon && (scl_oe !== 1'b0 || sda_oe !== 1'b0))
			bad <= 1'b1;
	end
	// ====
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// the answer as it stands at the completing edge
		@(negedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
			@(negedge pclk);
		end
		r = prdata;
		se = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic poll(input int b);
		for (int i = 0; i < 400; i++) begin
			rd(i2cs_pkg::OFS_STATUS);
			if (r[b] === 1'b1)
				break;
		end
	endtask
	// ====
	// scenarios
	task automatic s_regs();
		rd(i2cs_pkg::OFS_CTRL);
		chk(r, 32'h0);
		rd(i2cs_pkg::OFS_STATUS);
		chk(r, 32'h0);
		wr(i2cs_pkg::OFS_CMD, 32'h7);
		rd(i2cs_pkg::OFS_CMD);
		chk(r, 32'h4);
		wr(i2cs_pkg::OFS_CTRL, 32'hFF);
		rd(i2cs_pkg::OFS_CTRL);
		chk(r, {24'h0, i2cs_pkg::CTRL_MASK});
		rd(12'h3FC);
		chk({31'h0, se}, 32'h1);
		chk({30'h0, scl_out, sda_out}, 32'h0);
		wr(i2cs_pkg::OFS_CTRL, 32'h0);
		wr(i2cs_pkg::OFS_CMD, 32'h0);
	endtask
	task automatic s_dis();
		wr(i2cs_pkg::OFS_ADDR, 32'h84);
		mon <= 1'b1;
		host_u.start();
		host_u.byte_io(8'h84, ack);
		host_u.stop();
		mon <= 1'b0;
		chk({31'h0, ack}, 32'h1);
		chk({31'h0, bad}, 32'h0);
		rd(i2cs_pkg::OFS_STATUS);
		chk(r, 32'h0);
	endtask
	task automatic s_write();
		wr(i2cs_pkg::OFS_GIE, 32'h1);
		wr(i2cs_pkg::OFS_CTRL, 32'hA1);
		fork
			begin
				host_u.start();
				host_u.byte_io(8'h84, ack);
				host_u.byte_io(8'h5A, ack2);
				host_u.stop();
			end
			begin
				poll(i2cs_pkg::B_ADDRESS_OR_STOP_FLAG);
				chk(r, 32'h61);
				chk({31'h0, scl_oe}, 32'h1);
				chk({31'h0, addr_stop_irq}, 32'h0);
				wr(i2cs_pkg::OFS_CMD, 32'h3);
				rd(i2cs_pkg::OFS_STATUS);
				chk(r & 32'h60, 32'h0);
				poll(i2cs_pkg::B_DIF);
				chk(r & 32'hE0, 32'hA0);
				chk({31'h0, data_irq}, 32'h1);
				rd(i2cs_pkg::OFS_DATA);
				chk(r, 32'h5A);
				// nack and complete in one write
				wr(i2cs_pkg::OFS_CMD, 32'h6);
				poll(i2cs_pkg::B_ADDRESS_OR_STOP_FLAG);
				chk(r & 32'hC1, 32'h40);
			end
		join
		chk({31'h0, ack}, 32'h0);
		chk({31'h0, ack2}, 32'h1);
		wr(i2cs_pkg::OFS_CMD, 32'h0);
		rd(i2cs_pkg::OFS_STATUS);
		chk(r & 32'hC0, 32'h0);
	endtask
	task automatic s_prom();
		wr(i2cs_pkg::OFS_CTRL, 32'h05);
		fork
			begin
				host_u.start();
				host_u.byte_io(8'h91, ack);
				host_u.stop();
			end
			begin
				poll(i2cs_pkg::B_ADDRESS_OR_STOP_FLAG);
				chk(r, 32'h63);
				wr(i2cs_pkg::OFS_CMD, 32'h6);
			end
		join
		chk({31'h0, ack}, 32'h1);
		// start then stop at once is illegal
		host_u.start();
		host_u.stop();
		rd(i2cs_pkg::OFS_STATUS);
		chk(r & 32'h04, 32'h04);
		wr(i2cs_pkg::OFS_STATUS, 32'h04);
		rd(i2cs_pkg::OFS_STATUS);
		chk(r & 32'h04, 32'h0);
	endtask
	task automatic s_read();
		wr(i2cs_pkg::OFS_CTRL, 32'h03);
		fork
			begin
				host_u.start();
				host_u.byte_io(8'h85, ack);
				host_u.rd_byte(1'b1, rb);
				host_u.stop();
			end
			begin
				poll(i2cs_pkg::B_ADDRESS_OR_STOP_FLAG);
				chk(r, 32'h63);
				wr(i2cs_pkg::OFS_CMD, 32'h3);
				poll(i2cs_pkg::B_DIF);
				chk(r & 32'hE2, 32'hA2);
				// smart mode: the data write itself resumes
				wr(i2cs_pkg::OFS_DATA, 32'hA5);
				poll(i2cs_pkg::B_DIF);
				chk(r & 32'hF2, 32'hB2);
				wr(i2cs_pkg::OFS_CMD, 32'h2);
			end
		join
		chk({31'h0, ack}, 32'h0);
		chk({24'h0, rb}, 32'hA5);
	endtask
	// ====
	// run control
	task automatic end_of_test();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		end_of_test();
	end
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		presetn = 1'b0;
		mon = 1'b0;
		errors = 0;
		n_compared = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_dis();
		s_write();
		s_prom();
		s_read();
		end_of_test();
	end
endmodule
`default_nettype wire
